// ---- hw/dcgs_defines.svh ----
`ifndef DCGS_DEFINES_SVH
`define DCGS_DEFINES_SVH
`define DCGS_SYNC_RST 2'h0
`define DCGS_LOCK_RST 1'h1
`endif

// ---- hw/dcgs_gate_switch.sv ----
`timescale 1ns/1ps
`include "dcgs_defines.svh"
module dcgs_gate_switch
  import dcgs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic channel1_safety_input_i,
  input wire logic channel2_safety_input_i,
  input wire logic actuator_detected_i,
  output logic channel1_safety_output_o,
  output logic channel2_safety_output_o,
  output logic actuator_presence_output_o
);
  // pins are asynchronous; two stages before any use
  // trade-off: two clocks of latency buy metastability margin
  logic [1:0] sync_ch1;
  logic [1:0] sync_ch2;
  logic [1:0] sync_act;

  // settled levels: only the second stage of each synchroniser is read
  logic ch1_level;
  logic ch2_level;
  logic act_level;
  logic both_low;

  // two redundant locks, both needed to arm, so a single upset cannot release the outputs
  dcgs_state_t lock_a;
  dcgs_state_t lock_b;
  dcgs_state_t next_lock_a;
  dcgs_state_t next_lock_b;
  logic locks_agree;
  logic armed;

  // registered pin values and their next values
  logic ch1_out;
  logic ch2_out;
  logic presence;

  logic next_ch1_out;
  logic next_ch2_out;
  logic next_presence;

  function automatic logic [1:0] sync_step(
    input logic [1:0] stages,
    input logic pin
  );
    return {stages[0], pin};
  endfunction

  // the pair is compared; a lone low channel never counts as a release
  function automatic logic pair_low(
    input logic level_a,
    input logic level_b
  );
    return !level_a && !level_b;
  endfunction

  // a channel passes only while present and released from the lock
  function automatic logic channel_gate(
    input logic present,
    input logic released,
    input logic level
  );
    return present && released && level;
  endfunction

  // an unused code on either lock reads as disagreement, never as armed
  function automatic logic lock_valid(
    input dcgs_state_t value
  );
    logic ok;
    ok = 1'b0;
    case (value)
      dcgs_locked: begin
        ok = 1'b1;
      end
      dcgs_armed: begin
        ok = 1'b1;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  // next value of one lock; both locks use the same rule
  function automatic dcgs_state_t lock_step(
    input dcgs_state_t current,
    input logic present,
    input logic low_pair,
    input logic agree
  );
    dcgs_state_t result;
    result = current;
    case (current)
      dcgs_locked: begin
        if (present && low_pair && agree) begin
          result = dcgs_armed;
        end
      end
      dcgs_armed: begin
        // falling together is followed, not latched; actuator loss or lock disagreement relocks
        if (!present || !agree) begin
          result = dcgs_locked;
        end
      end
      default: begin
        result = dcgs_locked;
      end
    endcase
    return result;
  endfunction

  // reset clears both stages so no false level follows reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync_ch1 <= `DCGS_SYNC_RST;
    end else begin
      sync_ch1 <= sync_step(sync_ch1, channel1_safety_input_i);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync_ch2 <= `DCGS_SYNC_RST;
    end else begin
      sync_ch2 <= sync_step(sync_ch2, channel2_safety_input_i);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync_act <= `DCGS_SYNC_RST;
    end else begin
      sync_act <= sync_step(sync_act, actuator_detected_i);
    end
  end

  assign ch1_level = sync_ch1[1];
  assign ch2_level = sync_ch2[1];
  assign act_level = sync_act[1];

  assign both_low = pair_low(ch1_level, ch2_level);
  // disagreement between the two locks drops both channels
  assign locks_agree = lock_valid(lock_a) && lock_valid(lock_b)
    && (lock_a == lock_b);
  // both locks must say armed; one alone never enables
  assign armed = (lock_a == dcgs_armed) && (lock_b == dcgs_armed);

  always_comb begin
    next_lock_a = lock_step(lock_a, act_level, both_low, locks_agree);
  end

  always_comb begin
    next_lock_b = lock_step(lock_b, act_level, both_low, locks_agree);
  end

  // lock starts set so power-up also needs both inputs low first
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lock_a <= dcgs_locked;
    end else begin
      lock_a <= next_lock_a;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lock_b <= dcgs_locked;
    end else begin
      lock_b <= next_lock_b;
    end
  end

  // limitation: pulses shorter than one clock on a pin may be missed
  // single channel drop only follows low; staggered highs are tolerated
  always_comb begin
    next_presence = act_level;
  end

  always_comb begin
    next_ch1_out = channel_gate(act_level, armed, ch1_level);
  end

  always_comb begin
    next_ch2_out = channel_gate(act_level, armed, ch2_level);
  end

  // registered so the pins never glitch while a lock changes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      presence <= 1'b0;
    end else begin
      presence <= next_presence;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ch1_out <= 1'b0;
    end else begin
      ch1_out <= next_ch1_out;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ch2_out <= 1'b0;
    end else begin
      ch2_out <= next_ch2_out;
    end
  end

  // pins are driven straight from flip-flops
  assign channel1_safety_output_o = ch1_out;
  assign channel2_safety_output_o = ch2_out;
  assign actuator_presence_output_o = presence;

endmodule

// ---- hw/dcgs_pkg.sv ----
package dcgs_pkg;
  typedef enum logic [1:0] {
    dcgs_locked,
    dcgs_armed
  } dcgs_state_t;
endpackage

// ---- tb/dcgs_eval.sv ----
`timescale 1ns/1ps
module dcgs_eval(input wire logic a_i, input wire logic b_i, output logic run_o);
  assign run_o = a_i & b_i;
endmodule

// ---- tb/dcgs_gate_switch_assertions.sv ----
`timescale 1ns/1ps
module dcgs_chk(input wire logic clock_i, rst_i, channel1_safety_input_i,
  channel2_safety_input_i, actuator_detected_i, channel1_safety_output_o,
  channel2_safety_output_o, actuator_presence_output_o);
  wire a = actuator_detected_i;
  wire o1 = channel1_safety_output_o;
  wire o2 = channel2_safety_output_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  chk_presence_lag: assert property (!$past(rst_i,3) |-> actuator_presence_output_o == $past(a,3))
    else $error("presence lag");
  chk_absent_low: assert property (!$past(rst_i,3) && !$past(a,3) |-> !o1 && !o2)
    else $error("output without actuator");
  chk_ch1_cause: assert property (o1 |-> $past(channel1_safety_input_i,3))
    else $error("ch1 high without input");
  chk_ch2_cause: assert property (o2 |-> $past(channel2_safety_input_i,3))
    else $error("ch2 high without input");
  chk_out_presence: assert property (o1 || o2 |-> actuator_presence_output_o)
    else $error("output high while presence low");
  chk_lock_entry: assert property ($rose(actuator_presence_output_o) |-> !o1 && !o2)
    else $error("outputs on as actuator returns");
endmodule
bind dcgs_gate_switch dcgs_chk u_dcgs_chk(.*);

// ---- tb/dcgs_gate_switch_bench.sv ----
`timescale 1ns/1ps
module dcgs_gate_switch_bench;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("Error %0t mismatch", $time); end end
  logic clock_i = 0, rst_i = 1, c1 = 0, c2 = 0, a = 0, o1, o2, p;
  logic [3:0] h = 0, hc1 = 0, hc2 = 0;
  logic arm = 0, run;
  logic [1:0] want;
  int seed = 14402, miscompares = 0, cmp_count = 0, cyc = 0;
  dcgs_gate_switch u_dcgs_gate_switch(.clock_i, .rst_i, .channel1_safety_input_i(c1),
    .channel2_safety_input_i(c2), .actuator_detected_i(a), .channel1_safety_output_o(o1),
    .channel2_safety_output_o(o2), .actuator_presence_output_o(p));
  dcgs_eval u_dcgs_eval(.a_i(o1), .b_i(o2), .run_o(run));
  function automatic logic [1:0] expect_out(input logic act, en, x1, x2);
    return (act && en) ? {x1, x2} : 2'h0;
  endfunction
  initial forever #25 clock_i = ~clock_i;
  task test_done;
    $display("counts %0d %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock_i) if (++cyc == 900) begin
    miscompares++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 0;
    for (int i = 0; i < 500; i++) begin
      @(posedge clock_i);
      // long early presence with both low first, so the lock opens
      a <= i < 40 || $random(seed) % 8 != 0;
      {c1, c2} <= i < 20 ? 2'h0 : 2'($random(seed));
      @(negedge clock_i);
      want = expect_out(h[2], arm, hc1[2], hc2[2]);
      arm = h[2] && (arm || !(hc1[2] | hc2[2]));
      if (i > 4) begin
        `CHK(p, h[2])
        `CHK((o1 | o2) & ~h[2], 1'h0)
        `CHK({o1, o2}, want)
        `CHK(run, &want)
      end
      h = {h[2:0], a};
      hc1 = {hc1[2:0], c1};
      hc2 = {hc2[2:0], c2};
    end
    $display("random test done");
    test_done;
  end
endmodule
